// ---- hdl/kwdt_regs.vh ----
`ifndef KWDT_REGS_VH
`define KWDT_REGS_VH

// register byte offsets
`define KWDT_OFS_MODE 4'h0
`define KWDT_OFS_CLOCK 4'h4
`define KWDT_OFS_RESTART 4'h8
`define KWDT_OFS_STATUS 4'hC
`define KWDT_OFS_IRQ_STAT 4'h0
`define KWDT_OFS_IRQ_MASK 4'h4
`define KWDT_ADDR_W 5
`define KWDT_A_MODE 5'h00
`define KWDT_A_CLOCK 5'h04
`define KWDT_A_RESTART 5'h08
`define KWDT_A_STATUS 5'h0C
`define KWDT_A_IRQ_STAT 5'h10
`define KWDT_A_IRQ_MASK 5'h14

// overflow_mode fields
`define KWDT_MODE_EN 0
`define KWDT_MODE_RST 1
`define KWDT_MODE_IRQ 2
`define KWDT_MODE_PIN 3
`define KWDT_MODE_KEY 12'h234

// clock_mode fields
`define KWDT_CLK_KEY 9'h06E

// restart key
`define KWDT_RESTART_KEY 16'hC071

// reset values
`define KWDT_MODE_RESET 4'h0
`define KWDT_CLK_RESET 6'h00

// timing
`define KWDT_PIN_CYCLES 4'h8
`define KWDT_DIV_W 12
`define KWDT_SYSRST_CYCLES 4'h8

`endif

// ---- hdl/kwdt_prescaler.v ----
`timescale 1ns/1ps
`include "kwdt_regs.vh"

// free-running divider; one-cycle tick at the selected tap rate
module kwdt_prescaler (
    input wire clk_in,
    input wire reset_in,
    input wire [1:0] tick_select_in,
    output reg tick_out
);
    reg [`KWDT_DIV_W-1:0] div_q;
    reg [`KWDT_DIV_W-1:0] mask;

    // terminal mask for each tap: /32, /128, /1024, /4096
    always @* begin
        case (tick_select_in)
            2'h0: mask = 12'h01F;
            2'h1: mask = 12'h07F;
            2'h2: mask = 12'h3FF;
            default: mask = 12'hFFF;
        endcase
    end

    // counter and tick flop
    always @(posedge clk_in) begin
        if (reset_in) begin
            div_q <= 12'h000;
            tick_out <= 1'b0;
        end else begin
            div_q <= div_q + 12'h001;
            tick_out <= ((div_q & mask) == mask);
        end
    end
endmodule

// ---- hdl/kwdt_top.v ----
`timescale 1ns/1ps
`include "kwdt_regs.vh"

module kwdt_top (
    input wire clk_in,
    input wire reset_in,
    input wire [`KWDT_ADDR_W-1:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [31:0] rdata_out,
    output reg overflow_sys_reset_out,
    output reg overflow_irq_pulse_out,
    output reg overflow_pin_n_out,
    output reg irq_out
);
    reg [3:0] mode_q;
    reg [5:0] clk_mode_q;
    reg [15:0] count_q;
    reg seen_q;
    reg ovf_armed_q;
    reg [3:0] pin_cnt_q;
    reg [3:0] rst_cnt_q;
    reg [1:0] irq_stat_q;
    reg [1:0] irq_mask_q;
    wire tick;
    wire wr_mode;
    wire wr_clock;
    wire restart;
    wire ovf_event;
    wire [3:0] preload_nibble;
    reg [31:0] rdata_d;

    // access decode
    function wr_hit;
        input [`KWDT_ADDR_W-1:0] a;
        input [`KWDT_ADDR_W-1:0] target;
        begin
            wr_hit = (a == target);
        end
    endfunction

    assign wr_mode = wr_in && wr_hit(addr_in, `KWDT_A_MODE) &&
        (wdata_in[15:4] == `KWDT_MODE_KEY);
    assign wr_clock = wr_in && wr_hit(addr_in, `KWDT_A_CLOCK) &&
        (wdata_in[15:7] == `KWDT_CLK_KEY);
    assign restart = wr_in && wr_hit(addr_in, `KWDT_A_RESTART) &&
        (wdata_in[15:0] == `KWDT_RESTART_KEY);
    assign preload_nibble = clk_mode_q[5:2];

    // overflow: enabled counter at zero, once until next restart
    assign ovf_event = mode_q[`KWDT_MODE_EN] && (count_q == 16'h0000) &&
        ovf_armed_q && !restart;

    kwdt_prescaler u_pre (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .tick_select_in(clk_mode_q[1:0]),
        .tick_out(tick)
    );

    // keyed configuration registers
    always @(posedge clk_in) begin
        if (reset_in) begin
            mode_q <= `KWDT_MODE_RESET;
            clk_mode_q <= `KWDT_CLK_RESET;
        end else begin
            if (wr_mode) begin
                mode_q <= wdata_in[3:0];
            end
            if (wr_clock) begin
                clk_mode_q <= wdata_in[5:0];
            end
        end
    end

    // down counter with keyed restart
    always @(posedge clk_in) begin
        if (reset_in) begin
            count_q <= 16'hFFFF;
            ovf_armed_q <= 1'b1;
        end else if (restart) begin
            count_q <= {preload_nibble, 12'hFFF};
            ovf_armed_q <= 1'b1;
        end else begin
            if (ovf_event) begin
                ovf_armed_q <= 1'b0;
            end
            if (tick && mode_q[`KWDT_MODE_EN] && count_q != 16'h0000) begin
                count_q <= count_q - 16'h0001;
            end
        end
    end

    // status flag: set by overflow, cleared by restart or reset
    always @(posedge clk_in) begin
        if (reset_in) begin
            seen_q <= 1'b0;
        end else if (ovf_event) begin
            seen_q <= 1'b1;
        end else if (restart) begin
            seen_q <= 1'b0;
        end
    end

    // overflow outputs
    always @(posedge clk_in) begin
        if (reset_in) begin
            overflow_irq_pulse_out <= 1'b0;
            overflow_pin_n_out <= 1'b1;
            overflow_sys_reset_out <= 1'b0;
            pin_cnt_q <= 4'h0;
            rst_cnt_q <= 4'h0;
        end else begin
            overflow_irq_pulse_out <= ovf_event &&
                mode_q[`KWDT_MODE_IRQ];
            if (ovf_event && mode_q[`KWDT_MODE_PIN]) begin
                pin_cnt_q <= `KWDT_PIN_CYCLES;
                overflow_pin_n_out <= 1'b0;
            end else if (pin_cnt_q > 4'h1) begin
                pin_cnt_q <= pin_cnt_q - 4'h1;
                overflow_pin_n_out <= 1'b0;
            end else begin
                pin_cnt_q <= 4'h0;
                overflow_pin_n_out <= 1'b1;
            end
            if (ovf_event && mode_q[`KWDT_MODE_RST]) begin
                rst_cnt_q <= `KWDT_SYSRST_CYCLES;
                overflow_sys_reset_out <= 1'b1;
            end else if (rst_cnt_q > 4'h1) begin
                rst_cnt_q <= rst_cnt_q - 4'h1;
                overflow_sys_reset_out <= 1'b1;
            end else begin
                rst_cnt_q <= 4'h0;
                overflow_sys_reset_out <= 1'b0;
            end
        end
    end

    // sticky interrupt status (bit0 overflow, bit1 restart), set wins
    always @(posedge clk_in) begin
        if (reset_in) begin
            irq_stat_q <= 2'h0;
            irq_mask_q <= 2'h0;
            irq_out <= 1'b0;
        end else begin
            if (wr_in && wr_hit(addr_in, `KWDT_A_IRQ_STAT)) begin
                irq_stat_q <= (irq_stat_q & ~wdata_in[1:0]) |
                    {restart, ovf_event};
            end else begin
                irq_stat_q <= irq_stat_q | {restart, ovf_event};
            end
            if (wr_in && wr_hit(addr_in, `KWDT_A_IRQ_MASK)) begin
                irq_mask_q <= wdata_in[1:0];
            end
            irq_out <= |(irq_stat_q & irq_mask_q);
        end
    end

    // read mux; keys read as zero, unmapped reads zero
    always @* begin
        rdata_d = 32'h00000000;
        case (addr_in)
            `KWDT_A_MODE: rdata_d = {28'h0000000, mode_q};
            `KWDT_A_CLOCK: rdata_d = {26'h0000000, clk_mode_q};
            `KWDT_A_STATUS: rdata_d = {31'h00000000, seen_q};
            `KWDT_A_IRQ_STAT: rdata_d = {30'h00000000, irq_stat_q};
            `KWDT_A_IRQ_MASK: rdata_d = {30'h00000000, irq_mask_q};
            default: rdata_d = 32'h00000000;
        endcase
    end

    // read data register, valid in the cycle after the strobe
    always @(posedge clk_in) begin
        if (reset_in) begin
            rdata_out <= 32'h00000000;
        end else if (rd_in) begin
            rdata_out <= rdata_d;
        end else begin
            rdata_out <= 32'h00000000;
        end
    end
endmodule

// ---- sim/kwdt_properties.sv ----
`timescale 1ns/1ps
`include "kwdt_regs.vh"

module kwdt_properties (
    input wire clk_in,
    input wire reset_in,
    input wire [4:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [31:0] rdata_out,
    input wire overflow_sys_reset_out,
    input wire overflow_irq_pulse_out,
    input wire overflow_pin_n_out,
    input wire irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);

    // overflow outputs: lengths of the pulses
    a_pin_low_eight:
        assert property ($fell(overflow_pin_n_out) |->
        !overflow_pin_n_out [*8] ##1 overflow_pin_n_out)
        else $error("pin pulse length wrong");
    a_sysrst_eight:
        assert property ($rose(overflow_sys_reset_out) |->
        overflow_sys_reset_out [*8] ##1 !overflow_sys_reset_out)
        else $error("reset request length wrong");
    a_irq_single_pulse:
        assert property (overflow_irq_pulse_out |=> !overflow_irq_pulse_out)
        else $error("interrupt pulse too long");
    // a keyed restart leaves no room for an overflow
    a_restart_quiet:
        assert property (wr_in && addr_in == 5'h08 &&
        wdata_in[15:0] == 16'hC071 |=> !overflow_irq_pulse_out [*8])
        else $error("overflow right after restart");
    // read data: key fields, status high bits and write-only places read zero
    a_mode_key_zero:
        assert property (rd_in && addr_in == 5'h00 |=>
        rdata_out[31:4] == 28'h0) else $error("mode key not zero");
    a_clock_key_zero:
        assert property (rd_in && addr_in == 5'h04 |=>
        rdata_out[31:6] == 26'h0) else $error("clock key not zero");
    a_restart_reads_zero:
        assert property (rd_in && addr_in == 5'h08 |=>
        rdata_out == 32'h0) else $error("restart read not zero");
    a_status_one_bit:
        assert property (rd_in && addr_in == 5'h0C |=>
        rdata_out[31:1] == 31'h0) else $error("status high bits set");
endmodule

bind kwdt_top kwdt_properties u_props (.clk_in, .reset_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .overflow_sys_reset_out,
    .overflow_irq_pulse_out, .overflow_pin_n_out, .irq_out);

// ---- sim/kwdt_top_test.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value t=%0t got %h exp %h", $time, g, e); end end

module kwdt_top_test;
    reg clk_in = 0, reset_in = 1, wr_in = 0, rd_in = 0, rd_dly = 0;
    reg [4:0] addr_in = 5'h00;
    reg [31:0] wdata_in = 32'h0, rnd = 32'hE8A6, w, got_e;
    wire [31:0] rdata_out;
    wire sysrst, pulse, pin_n, irq;
    int err_count = 0, checks_done = 0, n;
    logic [31:0] exp_q[$];

    kwdt_top u_dut (.clk_in, .reset_in, .addr_in, .wdata_in, .wr_in,
        .rd_in, .rdata_out, .overflow_sys_reset_out(sysrst),
        .overflow_irq_pulse_out(pulse), .overflow_pin_n_out(pin_n),
        .irq_out(irq));

    // 50 MHz clock
    initial begin
        forever #10 clk_in = ~clk_in;
    end

    function [31:0] xs(input [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        xs = s ^ (s << 5);
    endfunction

    // one bus cycle, strobe dropped at the next edge
    task op(input w1, input r1, input [4:0] a, input [31:0] d);
        @(posedge clk_in);
        wr_in <= w1;
        rd_in <= r1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
    endtask

    task wr(input [4:0] a, input [31:0] d);
        op(1'b1, 1'b0, a, d);
    endtask

    // note the expected word, then read
    task rd(input [4:0] a, input [31:0] e);
        exp_q.push_back(e);
        op(1'b0, 1'b1, a, 32'h0);
    endtask

    task wrap_up;
        $display("mismatches %0d comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // read data stands the cycle after the strobe
    always @(posedge clk_in) begin
        if (rd_dly) begin
            got_e = exp_q.pop_front();
            `CHK(rdata_out, got_e)
        end
        rd_dly <= rd_in;
    end

    initial begin
        repeat (20) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(5'h00, 32'h0);
        rd(5'h04, 32'h0);
        rd(5'h0C, 32'h0);
        rd(5'h08, 32'h0);
        rd(5'h1C, 32'h0);
        wr(5'h00, 32'h234E);
        rd(5'h00, 32'hE);
        // every tick select, then preload nibble
        for (n = 0; n < 4; n++) begin
            wr(5'h04, 32'h3700 | 32'(n));
            rd(5'h04, 32'(n));
        end
        wr(5'h04, 32'h373F);
        rd(5'h04, 32'h3F);
        // random writes with broken keys change nothing
        for (n = 0; n < 4; n++) begin
            rnd = xs(rnd);
            wr(5'h00, rnd | 32'h10);
            wr(5'h04, rnd | 32'h80);
            wr(5'h08, rnd & 32'hFFFFFFFE);
            wr(5'h1C, rnd);
        end
        rd(5'h00, 32'hE);
        rd(5'h04, 32'h3F);
        rd(5'h10, 32'h0);
        // arm all outputs and let the counter run out
        wr(5'h04, 32'h3700);
        wr(5'h14, 32'h1);
        wr(5'h00, 32'h234F);
        wr(5'h08, 32'hC071);
        rd(5'h10, 32'h2);
        for (n = 0; n < 140000 && pulse !== 1'b1; n++) @(posedge clk_in);
        if (n == 140000) begin
            err_count++;
            wrap_up;
        end
        // pin and reset request are asserted together with the pulse
        #1 `CHK(pin_n, 1'b0)
        `CHK(sysrst, 1'b1)
        rd(5'h0C, 32'h1);
        rd(5'h10, 32'h3);
        #1 `CHK(irq, 1'b1)
        wr(5'h10, 32'h1);
        repeat (2) @(posedge clk_in);
        #1 `CHK(irq, 1'b0)
        // both eight-cycle outputs have ended by now
        `CHK(pin_n, 1'b1)
        `CHK(sysrst, 1'b0)
        rd(5'h10, 32'h2);
        wr(5'h08, 32'hC071);
        rd(5'h0C, 32'h0);
        wrap_up;
    end
endmodule
